// ---- hdl/tmc_pkg.sv ----
package tmc_pkg;

    // ****************************************
    // register map (word addresses on the bus)
    // ****************************************
    localparam logic [3:0] TMC_ADDR_COUNT = 4'h0;
    localparam logic [3:0] TMC_ADDR_COMP  = 4'h1;
    localparam logic [3:0] TMC_ADDR_CTRL  = 4'h2;
    localparam logic [3:0] TMC_ADDR_FLAGS = 4'h3;
    localparam logic [3:0] TMC_ADDR_MASK  = 4'h4;
    localparam logic [3:0] TMC_ADDR_GIE   = 4'h5;
    localparam logic [3:0] TMC_ADDR_ACK   = 4'h6;
    localparam logic [3:0] TMC_ADDR_STAT  = 4'h7;

    // ****************************************
    // control, flag and acknowledge register fields
    // ****************************************
    localparam int TMC_CS_LSB    = 0;
    localparam int TMC_WGM_LSB   = 3;
    localparam int TMC_COM_LSB   = 5;
    localparam int TMC_FOC_BIT   = 7;
    localparam int TMC_FLAG_OCF  = 1;
    localparam int TMC_FLAG_TOV  = 0;
    localparam int TMC_ACK_OCF   = 1;
    localparam int TMC_ACK_TOV   = 0;

    // ****************************************
    // values
    // ****************************************
    localparam logic [7:0] TMC_BOTTOM   = 8'h00;
    localparam logic [7:0] TMC_MAX      = 8'hff;
    localparam logic [7:0] TMC_RST_BYTE = 8'h00;
    localparam logic [2:0] TMC_CS_OFF   = 3'h0;
    localparam logic [2:0] TMC_CS_EXTF  = 3'h6;
    localparam logic [2:0] TMC_CS_EXTR  = 3'h7;

    localparam logic [1:0] TMC_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TMC_WGM_PCPWM  = 2'h1;
    localparam logic [1:0] TMC_WGM_CTC    = 2'h2;
    localparam logic [1:0] TMC_WGM_FAST   = 2'h3;

    localparam logic [1:0] TMC_COM_OFF = 2'h0;
    localparam logic [1:0] TMC_COM_TGL = 2'h1;
    localparam logic [1:0] TMC_COM_CLR = 2'h2;
    localparam logic [1:0] TMC_COM_SET = 2'h3;

    // prescaler taps: divide by 1, 8, 64, 256, 1024
    localparam int TMC_PRE_W = 10;

    typedef enum logic {
        TMC_DIR_UP,
        TMC_DIR_DOWN
    } tmc_dir_t;

    typedef struct packed {
        logic [1:0] com;
        logic [1:0] wgm;
        logic [2:0] cs;
    } tmc_ctrl_t;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } tmc_wb_req_t;

endpackage

// ---- hdl/tmc_timer.sv ----
`timescale 1ns/1ns
// How it works
// RQ1 - one channel; count and compare registers are eight bits each
// RQ2 - timer clock comes from internal prescaler or external pin per clock select
// RQ3 - clock select zero stops the timer; counter holds its value
// RQ4 - each timer clock clears, increments or decrements per waveform mode
// RQ5 - cpu reads/writes counter any time; a write beats count or clear
// RQ6 - bottom flags count 0x00, max flags count 0xff
// RQ7 - top is 0xff or the compare register depending on mode
// RQ8 - counter compared with compare register every cycle; equal gives match
// RQ9 - compare flag sets on the timer clock after the match
// RQ10 - compare irq only when flag, enable and global enable all set
// RQ11 - compare flag clears on irq acknowledge or writing one to it
// RQ12 - overflow flag set per mode and can raise an interrupt
// RQ13 - compare output driven from match per mode and output mode, extremes too
// RQ14 - compare register double buffered in pwm modes only
// RQ15 - buffered value moves to active compare only at top or bottom
// RQ16 - cpu reaches buffer when buffering, active register otherwise
// RQ17 - force strobe in non-pwm modes acts on output like a match
// RQ18 - forced compare sets no flag and leaves the counter alone
// RQ19 - counter write blocks matches in the next timer clock, even stopped
// RQ20 - software avoids writing bottom while counting down
// RQ21 - software sets output state before making the pin an output
// RQ22 - output state kept across waveform mode changes
// RQ23 - output mode field acts at once, not buffered
// RQ24 - mode 0 normal: always up, wraps 0xff to 0x00
// RQ25 - mode 2 clears counter on compare match
// RQ26 - mode 3 fast pwm: bottom to max then restart
// RQ27 - reset forces compare output state to zero
// RQ28 - mode 1 phase correct: up to max then down to bottom

module tmc_timer
    import tmc_pkg::*;
(
    // system
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pins and interrupt lines
    input  wire logic        external_clock_pin,
    output logic             compare_output,
    output logic             compare_irq,
    output logic             overflow_irq
);

    // ****************************************
    // bus decode
    // ****************************************
    tmc_wb_req_t req;
    logic        ack_q;
    logic        acc;
    logic        wr;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
    // a request is taken once; the cycle with ack high lets it go
    assign acc = req.cyc && req.stb && !ack_q;
    // only byte lane 0 carries register data
    assign wr  = acc && req.we && req.sel[0];

    function automatic logic wr_at(input logic [3:0] a);
        return wr && (req.adr == a);
    endfunction

    function automatic logic pwm_mode(input logic [1:0] wgm);
        return (wgm == TMC_WGM_PCPWM) || (wgm == TMC_WGM_FAST);
    endfunction

    // ****************************************
    // write strobes
    // ****************************************
    // a process, not assign: the strobes hang on what wr_at reads
    // outside its argument list, which only a comb process follows
    logic       count_wr;
    logic       comp_wr;
    logic       ctrl_wr;
    logic       mask_wr;
    logic       gie_wr;
    logic       force_cmp;
    logic [1:0] new_wgm;
    logic [1:0] new_com;
    logic [1:0] clr;

    always_comb begin
        count_wr  = wr_at(TMC_ADDR_COUNT);
        comp_wr   = wr_at(TMC_ADDR_COMP);
        ctrl_wr   = wr_at(TMC_ADDR_CTRL);
        mask_wr   = wr_at(TMC_ADDR_MASK);
        gie_wr    = wr_at(TMC_ADDR_GIE);
        new_wgm   = req.dat[TMC_WGM_LSB +: 2];
        new_com   = req.dat[TMC_COM_LSB +: 2];
        // the flag register and the irq acknowledge share one clear path
        clr       = 2'h0;
        if (wr_at(TMC_ADDR_FLAGS) || wr_at(TMC_ADDR_ACK)) begin
            clr = req.dat[1:0];                                      // RQ11
        end
        // a force obeys the mode bits written in the same access
        force_cmp = ctrl_wr && req.dat[TMC_FOC_BIT] && !pwm_mode(new_wgm); // RQ17 RQ23
    end

    // ****************************************
    // state
    // ****************************************
    tmc_ctrl_t  ctrl_q;
    logic [7:0] count_q;                                             // RQ1
    logic [7:0] comp_q;                                              // RQ1
    logic [7:0] comp_buf_q;
    logic [1:0] flags_q;
    logic [1:0] mask_q;
    logic       gie_q;
    logic       oc_q;
    tmc_dir_t   dir_q;
    logic       block_q;
    // free-running prescaler: a new select waits for its tap, so the
    // first timer clock after a select change may come early
    logic [TMC_PRE_W-1:0] pre_q;
    logic       ext_q;
    logic       ext_prev_q;

    // ****************************************
    // timer clock select
    // ****************************************
    logic tick;
    logic is_pwm;
    logic bottom;
    logic at_max;
    logic top;
    logic match;

    // the pin is sampled twice; the pair feeds the edge detector, which
    // puts every external edge two clocks behind the pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_q      <= '0;
            ext_q      <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            pre_q      <= pre_q + 1'b1;
            ext_q      <= external_clock_pin;
            ext_prev_q <= ext_q;
        end
    end

    // select zero gives no timer clock, so the counter and the flags rest
    always_comb begin
        case (ctrl_q.cs)                                             // RQ2
            3'h1:        tick = 1'b1;
            3'h2:        tick = (pre_q[2:0] == 3'h7);
            3'h3:        tick = (pre_q[5:0] == 6'h3f);
            3'h4:        tick = (pre_q[7:0] == 8'hff);
            3'h5:        tick = (pre_q == {TMC_PRE_W{1'b1}});
            TMC_CS_EXTF: tick = ext_prev_q && !ext_q;
            TMC_CS_EXTR: tick = !ext_prev_q && ext_q;
            default:     tick = 1'b0;                                // RQ3
        endcase
    end

    // ****************************************
    // compare and extremes
    // ****************************************
    assign is_pwm   = pwm_mode(ctrl_q.wgm);                          // RQ14
    assign bottom   = (count_q == TMC_BOTTOM);                      // RQ6
    assign at_max   = (count_q == TMC_MAX);                         // RQ6
    // top follows the mode: the compare value in clear-on-compare, max elsewhere
    assign top      = (ctrl_q.wgm == TMC_WGM_CTC) ? (count_q == comp_q) : at_max; // RQ7
    assign match    = (count_q == comp_q) && !block_q;              // RQ8 RQ19

    // a counter write blocks matches until the next timer clock has passed,
    // so equal count and compare right after a write raise no flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            block_q <= 1'b0;
        end else if (count_wr) begin
            block_q <= 1'b1;                                         // RQ19
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // ****************************************
    // counter
    // ****************************************
    // a cpu write wins over any count or clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= TMC_RST_BYTE;
            dir_q   <= TMC_DIR_UP;
        end else if (count_wr) begin
            count_q <= req.dat[7:0];                                 // RQ5
        end else if (tick) begin                                     // RQ4
            case (ctrl_q.wgm)
                TMC_WGM_CTC: begin
                    count_q <= match ? TMC_BOTTOM : count_q + 8'h01; // RQ25
                end
                // turning round at the ends keeps both slopes the same length
                TMC_WGM_PCPWM: begin                                 // RQ28
                    if (dir_q == TMC_DIR_UP && at_max) begin
                        dir_q   <= TMC_DIR_DOWN;
                        count_q <= count_q - 8'h01;
                    end else if (dir_q == TMC_DIR_DOWN && bottom) begin
                        dir_q   <= TMC_DIR_UP;
                        count_q <= count_q + 8'h01;
                    end else if (dir_q == TMC_DIR_DOWN) begin
                        count_q <= count_q - 8'h01;
                    end else begin
                        count_q <= count_q + 8'h01;
                    end
                end
                default: begin
                    // normal and fast pwm both wrap max to bottom
                    count_q <= count_q + 8'h01;                      // RQ24 RQ26
                    dir_q   <= TMC_DIR_UP;
                end
            endcase
        end
    end

    // ****************************************
    // compare register and its buffer
    // ****************************************
    // in pwm modes the cpu writes only the buffer; the active value is
    // loaded at max, so a period never sees half of an update
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            comp_q     <= TMC_RST_BYTE;
            comp_buf_q <= TMC_RST_BYTE;
        end else begin
            if (comp_wr) begin
                comp_buf_q <= req.dat[7:0];                          // RQ16
            end
            if (!is_pwm) begin
                if (comp_wr) begin
                    comp_q <= req.dat[7:0];                          // RQ16 RQ14
                end
            end else if (tick && at_max) begin
                // updating at max keeps each pwm period symmetrical
                comp_q <= comp_buf_q;                                // RQ15
            end
        end
    end

    // ****************************************
    // control, mask, global enable
    // ****************************************
    // a new output mode acts on the very next event; nothing holds it back
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0;
            mask_q <= '0;
            gie_q  <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= tmc_ctrl_t'(req.dat[6:0]);                 // RQ23
            end
            if (mask_wr) begin
                mask_q <= req.dat[1:0];
            end
            if (gie_wr) begin
                gie_q <= req.dat[0];
            end
        end
    end

    // ****************************************
    // flags: a hardware set wins over a clear
    // ****************************************
    logic ocf_set;
    logic tov_set;

    // forced compares never reach ocf_set, so they leave the flag alone
    assign ocf_set = tick && match;                                  // RQ9
    always_comb begin
        case (ctrl_q.wgm)
            TMC_WGM_PCPWM: tov_set = tick && bottom && dir_q == TMC_DIR_DOWN;
            default:       tov_set = tick && at_max;                 // RQ12
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q[TMC_FLAG_OCF] <= ocf_set
                || (flags_q[TMC_FLAG_OCF] && !clr[TMC_ACK_OCF]);     // RQ11 RQ18
            flags_q[TMC_FLAG_TOV] <= tov_set
                || (flags_q[TMC_FLAG_TOV] && !clr[TMC_ACK_TOV]);     // RQ12
        end
    end

    // irq lines are plain levels; they fall only when software clears
    // a flag, drops its enable or drops the global enable
    assign compare_irq  = flags_q[TMC_FLAG_OCF] && mask_q[TMC_FLAG_OCF] && gie_q; // RQ10
    assign overflow_irq = flags_q[TMC_FLAG_TOV] && mask_q[TMC_FLAG_TOV] && gie_q; // RQ12

    // ****************************************
    // waveform output
    // ****************************************

    function automatic logic com_act(input logic [1:0] com, input logic cur);
        case (com)
            TMC_COM_TGL: return !cur;
            TMC_COM_CLR: return 1'b0;
            TMC_COM_SET: return 1'b1;
            default:     return cur;
        endcase
    endfunction

    // state survives mode changes: only match, max or force touch it
    // com_act keeps the force path and the match path in step
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oc_q <= 1'b0;                                            // RQ27
        end else if (force_cmp) begin
            oc_q <= com_act(new_com, oc_q);                          // RQ17 RQ18
        end else if (tick) begin                                     // RQ13 RQ22
            if (!is_pwm) begin
                if (match) begin
                    oc_q <= com_act(ctrl_q.com, oc_q);
                end
            end else if (ctrl_q.com == TMC_COM_CLR || ctrl_q.com == TMC_COM_SET) begin
                // with compare at max the fast pwm action at max must win
                if (match && !(ctrl_q.wgm == TMC_WGM_FAST && comp_q == TMC_MAX)) begin
                    oc_q <= (ctrl_q.wgm == TMC_WGM_PCPWM && dir_q == TMC_DIR_DOWN)
                          ? (ctrl_q.com == TMC_COM_CLR) : (ctrl_q.com == TMC_COM_SET);
                end else if (ctrl_q.wgm == TMC_WGM_FAST && at_max) begin
                    oc_q <= (ctrl_q.com == TMC_COM_CLR);
                end
            end
        end
    end
    assign compare_output = oc_q;

    // ****************************************
    // read back and acknowledge
    // ****************************************
    // ack is a registered pulse: every access costs one wait state, and
    // a request still standing while ack is high is not taken twice
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q    <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack_q <= acc;
            if (acc && !req.we) begin
                if (req.adr == TMC_ADDR_COUNT) begin
                    wb_dat_o <= {24'h0, count_q};                    // RQ5
                end else if (req.adr == TMC_ADDR_COMP) begin
                    wb_dat_o <= {24'h0, is_pwm ? comp_buf_q : comp_q}; // RQ16
                end else if (req.adr == TMC_ADDR_CTRL) begin
                    wb_dat_o <= {25'h0, ctrl_q};
                end else if (req.adr == TMC_ADDR_FLAGS) begin
                    wb_dat_o <= {30'h0, flags_q};
                end else if (req.adr == TMC_ADDR_MASK) begin
                    wb_dat_o <= {30'h0, mask_q};
                end else if (req.adr == TMC_ADDR_GIE) begin
                    wb_dat_o <= {31'h0, gie_q};
                end else if (req.adr == TMC_ADDR_STAT) begin
                    wb_dat_o <= {27'h0, dir_q == TMC_DIR_DOWN, oc_q, top, at_max, bottom};
                end else begin
                    wb_dat_o <= '0;
                end
            end
        end
    end
    assign wb_ack_o = ack_q;

endmodule

// ---- test/tmc_timer_checker.sv ----
`timescale 1ns/1ns
// ****************************************
// port-level checks of the timer block
// ****************************************
module tmc_timer_checker
    import tmc_pkg::*;
(
    // system
    input wire logic        sys_clk,
    input wire logic        rst,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic        external_clock_pin,
    input wire logic        compare_output,
    input wire logic        compare_irq,
    input wire logic        overflow_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_rdata_holds: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && !wb_we_i))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i[3] |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_out_after_reset: assert property ($fell(rst) |-> !compare_output && !compare_irq
        && !overflow_irq)
        else $error("outputs not cleared by reset");
    // an irq can only be dropped by software, never by the counter itself
    a_cirq_sw_clear: assert property ($fell(compare_irq) |-> $past(wb_cyc_i && wb_we_i))
        else $error("compare irq dropped without a write");
    a_oirq_sw_clear: assert property ($fell(overflow_irq) |-> $past(wb_cyc_i && wb_we_i))
        else $error("overflow irq dropped without a write");

    c_cirq: cover property ($rose(compare_irq));
    c_oirq: cover property ($rose(overflow_irq));
    c_oc_rise: cover property ($rose(compare_output));
endmodule

bind tmc_timer tmc_timer_checker u_chk (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_clock_pin(external_clock_pin), .compare_output(compare_output),
    .compare_irq(compare_irq), .overflow_irq(overflow_irq));

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
    import tmc_pkg::*;
;
    logic        sys_clk, rst, ext_pin, wb_ack_o, compare_output, compare_irq, overflow_irq;
    logic [31:0] wb_dat_o;
    tmc_wb_req_t req;
    logic [63:0] exp_q[$];
    logic [63:0] ent;
    logic [7:0]  r;
    logic        prev;
    logic [1:0]  coms [4] = '{TMC_COM_SET, TMC_COM_CLR, TMC_COM_TGL, TMC_COM_TGL};
    int          fails, checks_done, toggles;

    tmc_timer dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_clock_pin(ext_pin),
        .compare_output(compare_output), .compare_irq(compare_irq),
        .overflow_irq(overflow_irq));

    always #50 sys_clk = ~sys_clk;

    // ****************************************
    // bus tasks and result watcher
    // ****************************************
    function automatic logic [7:0] ctl(input logic [1:0] com, wgm, input logic [2:0] cs);
        return {1'b0, com, wgm, cs};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h0, d}};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        req <= '0;
        if (wb_ack_o !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: no ack", $time);
            give_verdict();
        end else begin
            @(posedge sys_clk);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({24'h0, e, 24'hffffff, m});
        wb(1'b0, a, 8'h0);
    endtask

    task automatic chk(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: pin level %b", $time, g);
        end
    endtask

    // timer runs off sys_clk (select 1) for a short burst, then stops
    task automatic burst(input logic [1:0] wgm);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, wgm, 3'h1));
        repeat (4) @(posedge sys_clk);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, wgm, TMC_CS_OFF));
    endtask

    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && req.we === 1'b0) begin
            ent = exp_q.pop_front();
            checks_done++;
            if ((wb_dat_o & ent[31:0]) !== ent[63:32]) begin
                fails++;
                $display("mismatch at %0t: read %h", $time, wb_dat_o);
            end
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        sys_clk = 0; rst = 1; ext_pin = 0; req = '0; fails = 0; checks_done = 0;
        void'($urandom(87960));
        r = 8'($urandom());
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 16; i++) rd(4'(i), (i == 7) ? 8'h01 : 8'h00, 8'hff);
        chk(compare_output, 1'b0);
        wb(1'b1, TMC_ADDR_COUNT, r);
        wb(1'b1, 4'h9, 8'ha5);
        wb(1'b1, TMC_ADDR_COMP, ~r);
        repeat (5) @(posedge sys_clk);
        rd(TMC_ADDR_COUNT, r, 8'hff);
        rd(4'h9, 8'h00, 8'hff);
        rd(TMC_ADDR_COMP, ~r, 8'hff);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, TMC_ADDR_CTRL, ctl(coms[i], TMC_WGM_NORMAL, TMC_CS_OFF) | 8'h80);
            chk(compare_output, i[0] == 1'b0);
        end
        rd(TMC_ADDR_FLAGS, 8'h00, 8'hff);
        rd(TMC_ADDR_COUNT, r, 8'hff);
        rd(TMC_ADDR_CTRL, ctl(TMC_COM_TGL, TMC_WGM_NORMAL, TMC_CS_OFF), 8'hff);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_SET, TMC_WGM_NORMAL, TMC_CS_OFF) | 8'h80);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, TMC_WGM_CTC, TMC_CS_OFF));
        chk(compare_output, 1'b1);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, TMC_WGM_NORMAL, TMC_CS_OFF));
        wb(1'b1, TMC_ADDR_COUNT, 8'h10);
        wb(1'b1, TMC_ADDR_COMP, 8'h11);
        wb(1'b1, TMC_ADDR_MASK, 8'h02);
        wb(1'b1, TMC_ADDR_GIE, 8'h01);
        burst(TMC_WGM_NORMAL);
        rd(TMC_ADDR_FLAGS, 8'h02, 8'h02);
        chk(compare_irq, 1'b1);
        wb(1'b1, TMC_ADDR_GIE, 8'h00);
        chk(compare_irq, 1'b0);
        wb(1'b1, TMC_ADDR_GIE, 8'h01);
        wb(1'b1, TMC_ADDR_MASK, 8'h00);
        chk(compare_irq, 1'b0);
        wb(1'b1, TMC_ADDR_MASK, 8'h02);
        chk(compare_irq, 1'b1);
        wb(1'b1, TMC_ADDR_ACK, 8'h02);
        chk(compare_irq, 1'b0);
        // equal count and compare at start: the first tick must not flag
        wb(1'b1, TMC_ADDR_COMP, 8'h40);
        wb(1'b1, TMC_ADDR_COUNT, 8'h40);
        burst(TMC_WGM_NORMAL);
        rd(TMC_ADDR_FLAGS, 8'h00, 8'h02);
        wb(1'b1, TMC_ADDR_COUNT, 8'h3f);
        burst(TMC_WGM_NORMAL);
        rd(TMC_ADDR_FLAGS, 8'h02, 8'h02);
        wb(1'b1, TMC_ADDR_FLAGS, 8'h02);
        rd(TMC_ADDR_FLAGS, 8'h00, 8'h02);
        wb(1'b1, TMC_ADDR_MASK, 8'h01);
        wb(1'b1, TMC_ADDR_COUNT, 8'hfd);
        burst(TMC_WGM_NORMAL);
        rd(TMC_ADDR_FLAGS, 8'h01, 8'h01);
        rd(TMC_ADDR_COUNT, 8'h00, 8'hf8);
        chk(overflow_irq, 1'b1);
        wb(1'b1, TMC_ADDR_FLAGS, 8'h01);
        chk(overflow_irq, 1'b0);
        wb(1'b1, TMC_ADDR_COMP, 8'h03);
        wb(1'b1, TMC_ADDR_COUNT, 8'h00);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, TMC_WGM_CTC, 3'h1));
        repeat (20) @(posedge sys_clk);
        rd(TMC_ADDR_COUNT, 8'h00, 8'hfc);
        // stop the running counter first, so the start value survives
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, TMC_WGM_PCPWM, TMC_CS_OFF));
        wb(1'b1, TMC_ADDR_COUNT, 8'hfd);
        burst(TMC_WGM_PCPWM);
        rd(TMC_ADDR_STAT, 8'h10, 8'h10);
        wb(1'b1, TMC_ADDR_COUNT, 8'h00);
        wb(1'b1, TMC_ADDR_COMP, 8'h80);
        rd(TMC_ADDR_COMP, 8'h80, 8'hff);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_CLR, TMC_WGM_FAST, 3'h1));
        toggles = 0;
        prev = compare_output;
        repeat (700) begin
            @(posedge sys_clk);
            if (compare_output !== prev) toggles++;
            prev = compare_output;
        end
        chk(toggles > 2, 1'b1);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, TMC_WGM_NORMAL, TMC_CS_OFF));
        wb(1'b1, TMC_ADDR_COUNT, 8'h00);
        wb(1'b1, TMC_ADDR_CTRL, ctl(TMC_COM_OFF, TMC_WGM_NORMAL, TMC_CS_EXTR));
        // slow pulses leave room for the input synchroniser lag
        repeat (5) begin
            ext_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            ext_pin <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        rd(TMC_ADDR_COUNT, 8'h05, 8'hff);
        give_verdict();
    end
endmodule
